// ===== core/bus_unit_pkg.sv
// Purpose: shared constants of the bus unit acknowledge and control decoder
// Assumes: 12-bit unit addresses, 4-bit control codes, 8-bit length and data fields
// Notes:   field kind codes are the encoding of the FIELD_KIND port
package bus_unit_pkg;

    // ==================================================================
    // field kinds reported by the bit layer
    localparam logic [2:0] KIND_MASTER_ADDR = 3'h0;
    localparam logic [2:0] KIND_SLAVE_ADDR  = 3'h1;
    localparam logic [2:0] KIND_CONTROL     = 3'h2;
    localparam logic [2:0] KIND_LENGTH      = 3'h3;
    localparam logic [2:0] KIND_DATA        = 3'h4;

    // ==================================================================
    // control codes
    localparam logic [3:0] CODE_STATUS        = 4'h0;
    localparam logic [3:0] CODE_READ_LOCK     = 4'h3;
    localparam logic [3:0] CODE_LOCK_ADDR_LO  = 4'h4;
    localparam logic [3:0] CODE_LOCK_ADDR_HI  = 4'h5;
    localparam logic [3:0] CODE_STATUS_UNLOCK = 4'h6;
    localparam logic [3:0] CODE_READ          = 4'h7;
    localparam logic [3:0] CODE_CMD_LOCK      = 4'hA;
    localparam logic [3:0] CODE_WRITE_LOCK    = 4'hB;
    localparam logic [3:0] CODE_CMD           = 4'hE;
    localparam logic [3:0] CODE_WRITE         = 4'hF;
    localparam int         CODE_DIR_BIT       = 3;

    // ==================================================================
    // addresses and lengths
    localparam logic [11:0] GENERAL_BCAST_ADDR = 12'hFFF;
    localparam logic [8:0]  LENGTH_ZERO_MEANS  = 9'h100;

    // ==================================================================
    // slave status byte layout
    localparam int         STAT_TX_NOT_EMPTY = 0;
    localparam int         STAT_RX_NOT_EMPTY = 1;
    localparam int         STAT_LOCKED       = 2;
    localparam int         STAT_TX_ENABLED   = 4;
    localparam logic [1:0] STAT_SPEED_MODE   = 2'h2;
    localparam logic [7:0] STATUS_RESET      = 8'h80;

endpackage

// ===== core/lock_tracker.sv
// Purpose: holds the lock state of the unit and the address of the lock owner
// Assumes: set and clear are one-cycle pulses from the frame-end decision
// Notes:   set wins when both arrive together
`timescale 1ns/1ps
`default_nettype none
module lock_tracker (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        lock_set,
    input  wire logic        lock_clear,
    input  wire logic [11:0] owner_in,
    output logic             locked,
    output logic      [11:0] owner
);

    // ==================================================================
    // lock flag
    always_ff @(posedge clk) begin
        if (rst) begin
            locked <= 1'b0;
        end else if (lock_set) begin
            locked <= 1'b1;
        end else if (lock_clear) begin
            locked <= 1'b0;
        end
    end

    // ==================================================================
    // owner address, kept after unlock so a late read shows the last owner
    always_ff @(posedge clk) begin
        if (rst) begin
            owner <= 12'h000;
        end else if (lock_set) begin
            owner <= owner_in;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_lock_owner_capture: assert property (lock_set |=> locked && owner == $past(owner_in))
        else $error("lock owner not captured on lock");
    chk_lock_release: assert property (lock_clear && !lock_set |=> !locked)
        else $error("unit still locked after clear");

endmodule
`default_nettype wire

// ===== core/bus_unit_ack_and_control_decoder.sv
// Purpose: field checking, acknowledge decision and control decoding of a bus unit
// Assumes: the bit layer reports each received field once, with its parity bit
// Notes:   ACK_BIT 0 is acknowledge, 1 is no acknowledge
//
// Overview of operation
// - even parity bit is one for odd ones
// - parity checked per address, control, length, data
// - acknowledge zero means recognized, one means refused
// - broadcast transfers drive no acknowledge
// - slave address refused on parity, timing, mismatch
// - control refused on parity or timing error
// - write refused while receive buffer busy
// - data read refused when transmit buffer empty
// - locked unit refuses foreign masters except 0,4,5
// - low lock address read (code 4) refused when unlocked
// - undefined control codes never acknowledged
// - length refused on parity or timing error
// - data refused on parity, timing, full buffer
// - refused byte resent until accepted
// - control bit 3 sets data direction
// - defined control codes decoded to functions
// - status bits show buffers and lock
// - status bits 3,5 zero, bit 4 configured
// - status speed bits fixed at 10
// - status taken from last communication outcome
// - lock address returned low byte, high nibble
// - buffers valid only when their flags set
// - lock on early end after length acknowledge
// - unlock when full count done in frame
// - control field four bits, parity, acknowledge
`timescale 1ns/1ps
`default_nettype none
module bus_unit_ack_and_control_decoder (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        FIELD_VALID,
    input  wire logic [2:0]  FIELD_KIND,
    input  wire logic [11:0] FIELD_BITS,
    input  wire logic        FIELD_PARITY,
    input  wire logic        TIMING_ERR,
    input  wire logic        BROADCAST,
    input  wire logic        FRAME_END,
    input  wire logic        READ_BYTE_ACKED,
    input  wire logic [11:0] UNIT_ADDR,
    input  wire logic        SLAVE_TX_REQUEST,
    input  wire logic        SLAVE_RX_ENABLE,
    input  wire logic        SLAVE_TX_ENABLE_CFG,
    input  wire logic        TX_FIFO_EMPTY,
    input  wire logic [7:0]  TX_FIFO_DATA,
    input  wire logic        RX_FIFO_EMPTY,
    input  wire logic        RX_FIFO_FULL,
    input  wire logic [11:0] PAR_IN,
    output logic             PAR_OUT,
    output logic             ACK_VALID,
    output logic             ACK_BIT,
    output logic             STOP,
    output logic [3:0]       CMD_CODE,
    output logic             DIR_TO_SLAVE,
    output logic [7:0]       REPLY_BYTE,
    output logic [7:0]       RX_DATA,
    output logic             RX_PUSH,
    output logic             TX_POP,
    output logic [7:0]       STATUS_BYTE,
    output logic             LOCKED,
    output logic [11:0]      LOCK_OWNER
);

    typedef enum logic [2:0] {ST_IDLE, ST_SLAVE, ST_CTRL, ST_LEN, ST_DATA} state_t;

    // ==================================================================
    // helpers
    function automatic logic parity_of(input logic [11:0] bits);
        parity_of = ^bits;
    endfunction

    function automatic logic code_defined(input logic [3:0] c);
        code_defined = !(c == 4'h1 || c == 4'h2 || c == 4'h8 || c == 4'h9 ||
                         c == 4'hC || c == 4'hD);
    endfunction

    function automatic logic code_data_read(input logic [3:0] c);
        code_data_read = (c == bus_unit_pkg::CODE_READ_LOCK) || (c == bus_unit_pkg::CODE_READ);
    endfunction

    function automatic logic code_locking(input logic [3:0] c);
        code_locking = (c == bus_unit_pkg::CODE_READ_LOCK) ||
                       (c == bus_unit_pkg::CODE_CMD_LOCK) ||
                       (c == bus_unit_pkg::CODE_WRITE_LOCK);
    endfunction

    function automatic logic code_lock_exempt(input logic [3:0] c);
        code_lock_exempt = (c == bus_unit_pkg::CODE_STATUS) ||
                           (c == bus_unit_pkg::CODE_LOCK_ADDR_LO) ||
                           (c == bus_unit_pkg::CODE_LOCK_ADDR_HI);
    endfunction

    state_t      state_r;
    state_t      state_nxt;
    logic [11:0] master_r;
    logic        mpar_ok_r;
    logic        terr_r;
    logic [3:0]  code_r;
    logic [8:0]  len_r;
    logic [8:0]  count_r;
    logic        len_acked_r;
    logic        bcast_r;
    logic        par_bad;
    logic        terr_now;
    logic        addr_match;
    logic        tx_buf_empty;
    logic        rx_buf_busy;
    logic        field_nak;
    logic        answers;
    logic        stops;
    logic        byte_ok;
    logic        done;
    logic        lock_set;
    logic        lock_clear;
    logic [3:0]  ctl;
    logic [7:0]  live_status;

    assign ctl      = FIELD_BITS[3:0];
    assign par_bad  = parity_of(FIELD_BITS) != FIELD_PARITY;
    assign terr_now = terr_r || TIMING_ERR;
    assign done     = (count_r == len_r);
    assign addr_match = (FIELD_BITS == UNIT_ADDR) ||
                        (BROADCAST && (FIELD_BITS == bus_unit_pkg::GENERAL_BCAST_ADDR ||
                                       FIELD_BITS[11:8] == UNIT_ADDR[11:8]));
    // a buffer whose flag is off counts as unavailable
    assign tx_buf_empty = !SLAVE_TX_REQUEST || TX_FIFO_EMPTY;
    assign rx_buf_busy  = !SLAVE_RX_ENABLE || !RX_FIFO_EMPTY;

    // ==================================================================
    // per-field decision
    always_comb begin
        field_nak = 1'b0;
        answers   = 1'b0;
        stops     = 1'b0;
        byte_ok   = 1'b0;
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (FIELD_VALID && FIELD_KIND == bus_unit_pkg::KIND_MASTER_ADDR) begin
                    state_nxt = ST_SLAVE;
                end
            end
            ST_SLAVE: begin
                if (FIELD_VALID && FIELD_KIND == bus_unit_pkg::KIND_SLAVE_ADDR) begin
                    answers   = 1'b1;
                    field_nak = !mpar_ok_r || par_bad || terr_now || !addr_match;
                    stops     = field_nak;
                    state_nxt = field_nak ? ST_IDLE : ST_CTRL;
                end
            end
            ST_CTRL: begin
                if (FIELD_VALID && FIELD_KIND == bus_unit_pkg::KIND_CONTROL) begin
                    answers   = 1'b1;
                    field_nak = par_bad || terr_now
                             || !code_defined(ctl)
                             || (ctl[bus_unit_pkg::CODE_DIR_BIT] && rx_buf_busy)
                             || (code_data_read(ctl) && tx_buf_empty)
                             || (LOCKED && master_r != LOCK_OWNER &&
                                 !code_lock_exempt(ctl))
                             || (ctl == bus_unit_pkg::CODE_LOCK_ADDR_LO && !LOCKED);
                    stops     = field_nak;
                    state_nxt = field_nak ? ST_IDLE : ST_LEN;
                end
            end
            ST_LEN: begin
                if (FIELD_VALID && FIELD_KIND == bus_unit_pkg::KIND_LENGTH) begin
                    // in reads we send the length and the master answers it
                    answers   = code_r[bus_unit_pkg::CODE_DIR_BIT];
                    field_nak = answers && (par_bad || terr_now);
                    stops     = field_nak;
                    state_nxt = field_nak ? ST_IDLE : ST_DATA;
                end
            end
            ST_DATA: begin
                if (FIELD_VALID && FIELD_KIND == bus_unit_pkg::KIND_DATA &&
                    code_r[bus_unit_pkg::CODE_DIR_BIT] && !done) begin
                    answers   = 1'b1;
                    // no stop: the sender retries the same byte
                    field_nak = par_bad || terr_now || RX_FIFO_FULL;
                    byte_ok   = !field_nak;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (FRAME_END) begin
            state_nxt = ST_IDLE;
        end
    end

    // ==================================================================
    // frame state
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            master_r  <= 12'h000;
            mpar_ok_r <= 1'b0;
            bcast_r   <= 1'b0;
        end else if (state_r == ST_IDLE && FIELD_VALID &&
                     FIELD_KIND == bus_unit_pkg::KIND_MASTER_ADDR) begin
            master_r  <= FIELD_BITS;
            mpar_ok_r <= !par_bad;
            bcast_r   <= BROADCAST;
        end
    end

    // timing errors since the previous acknowledge; a new error beats the clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            terr_r <= 1'b0;
        end else if (TIMING_ERR) begin
            terr_r <= 1'b1;
        end else if (answers || FRAME_END) begin
            terr_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            code_r <= bus_unit_pkg::CODE_STATUS;
        end else if (state_r == ST_CTRL && answers && !field_nak) begin
            code_r <= ctl;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            len_r       <= 9'h000;
            len_acked_r <= 1'b0;
        end else if (state_r == ST_LEN && FIELD_VALID &&
                     FIELD_KIND == bus_unit_pkg::KIND_LENGTH && !field_nak) begin
            len_r       <= (FIELD_BITS[7:0] == 8'h00) ? bus_unit_pkg::LENGTH_ZERO_MEANS
                                                      : {1'b0, FIELD_BITS[7:0]};
            len_acked_r <= 1'b1;
        end else if (FRAME_END || state_r == ST_IDLE) begin
            len_acked_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || state_r != ST_DATA) begin
            count_r <= 9'h000;
        end else if (byte_ok || (READ_BYTE_ACKED && !done)) begin
            count_r <= count_r + 9'h001;
        end
    end

    // ==================================================================
    // acknowledge and data outputs
    always_ff @(posedge CLK) begin
        if (RST) begin
            ACK_VALID <= 1'b0;
            ACK_BIT   <= 1'b1;
            STOP      <= 1'b0;
        end else begin
            ACK_VALID <= answers && !BROADCAST;
            ACK_BIT   <= (answers && !BROADCAST) ? field_nak : 1'b1;
            STOP      <= stops;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            RX_PUSH <= 1'b0;
            RX_DATA <= 8'h00;
            TX_POP  <= 1'b0;
        end else begin
            RX_PUSH <= byte_ok;
            if (byte_ok) begin
                RX_DATA <= FIELD_BITS[7:0];
            end
            // the read pointer only moves on the master's acknowledge
            TX_POP  <= state_r == ST_DATA && READ_BYTE_ACKED && !done &&
                       code_data_read(code_r);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            PAR_OUT <= 1'b0;
        end else begin
            PAR_OUT <= parity_of(PAR_IN);
        end
    end

    assign CMD_CODE     = code_r;
    assign DIR_TO_SLAVE = code_r[bus_unit_pkg::CODE_DIR_BIT];

    // ==================================================================
    // lock handling, not for broadcast
    assign lock_set   = FRAME_END && !bcast_r && len_acked_r && code_locking(code_r) &&
                        !done;
    assign lock_clear = FRAME_END && !bcast_r && len_acked_r && done &&
                        (code_locking(code_r) || code_r == bus_unit_pkg::CODE_STATUS_UNLOCK);

    lock_tracker u_lock (
        .clk        (CLK),
        .rst        (RST),
        .lock_set   (lock_set),
        .lock_clear (lock_clear),
        .owner_in   (master_r),
        .locked     (LOCKED),
        .owner      (LOCK_OWNER)
    );

    // ==================================================================
    // slave status, sampled when a communication ends
    always_comb begin
        live_status = {bus_unit_pkg::STAT_SPEED_MODE, 6'h00};
        live_status[bus_unit_pkg::STAT_TX_NOT_EMPTY] = !tx_buf_empty;
        live_status[bus_unit_pkg::STAT_RX_NOT_EMPTY] = SLAVE_RX_ENABLE && !RX_FIFO_EMPTY;
        live_status[bus_unit_pkg::STAT_LOCKED]       = LOCKED;
        live_status[bus_unit_pkg::STAT_TX_ENABLED]   = SLAVE_TX_ENABLE_CFG;
    end

    // taken one cycle after the end so the lock outcome is included
    logic snap_r;
    always_ff @(posedge CLK) begin
        if (RST) begin
            snap_r      <= 1'b0;
            STATUS_BYTE <= bus_unit_pkg::STATUS_RESET;
        end else begin
            snap_r <= FRAME_END || stops;
            if (snap_r) begin
                STATUS_BYTE <= live_status;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            REPLY_BYTE <= 8'h00;
        end else begin
            case (code_r)
                bus_unit_pkg::CODE_LOCK_ADDR_LO: REPLY_BYTE <= LOCK_OWNER[7:0];
                bus_unit_pkg::CODE_LOCK_ADDR_HI: REPLY_BYTE <= {4'h0, LOCK_OWNER[11:8]};
                bus_unit_pkg::CODE_READ_LOCK,
                bus_unit_pkg::CODE_READ:         REPLY_BYTE <= TX_FIFO_DATA;
                default:                         REPLY_BYTE <= STATUS_BYTE;
            endcase
        end
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_parity_gen: assert property (##1 PAR_OUT == ^$past(PAR_IN))
        else $error("parity output wrong");
    chk_bcast_silent: assert property (FIELD_VALID && BROADCAST |=> !ACK_VALID)
        else $error("acknowledge driven in broadcast");
    chk_slave_nak: assert property (state_r == ST_SLAVE && FIELD_VALID &&
        FIELD_KIND == bus_unit_pkg::KIND_SLAVE_ADDR && par_bad |=> ACK_BIT && STOP)
        else $error("bad slave address parity not refused");
    chk_undef_code: assert property (state_r == ST_CTRL && FIELD_VALID &&
        FIELD_KIND == bus_unit_pkg::KIND_CONTROL && !code_defined(ctl)
        |=> ACK_BIT && STOP ##1 state_r == ST_IDLE)
        else $error("undefined control code accepted");
    chk_write_busy: assert property (state_r == ST_CTRL && FIELD_VALID &&
        FIELD_KIND == bus_unit_pkg::KIND_CONTROL && ctl[3] && rx_buf_busy |=> ACK_BIT)
        else $error("write accepted with receive buffer busy");
    chk_read_empty: assert property (state_r == ST_CTRL && FIELD_VALID &&
        FIELD_KIND == bus_unit_pkg::KIND_CONTROL && code_data_read(ctl) && tx_buf_empty
        |=> ACK_BIT)
        else $error("data read accepted with empty transmit buffer");
    chk_foreign_master: assert property (state_r == ST_CTRL && FIELD_VALID &&
        FIELD_KIND == bus_unit_pkg::KIND_CONTROL && LOCKED && master_r != LOCK_OWNER &&
        !code_lock_exempt(ctl) |=> ACK_BIT && $past(state_nxt) == ST_IDLE)
        else $error("foreign master accepted while locked");
    chk_lockaddr_unlocked: assert property (state_r == ST_CTRL && FIELD_VALID &&
        FIELD_KIND == bus_unit_pkg::KIND_CONTROL && ctl == 4'h4 && !LOCKED |=> ACK_BIT)
        else $error("lock address read accepted while unlocked");
    chk_len_nak: assert property (state_r == ST_LEN && FIELD_VALID &&
        FIELD_KIND == bus_unit_pkg::KIND_LENGTH && code_r[3] && par_bad |=> STOP)
        else $error("bad length parity not refused");
    chk_full_refused: assert property (state_r == ST_DATA && FIELD_VALID &&
        FIELD_KIND == bus_unit_pkg::KIND_DATA && RX_FIFO_FULL |=> !RX_PUSH && ACK_BIT)
        else $error("data pushed into a full buffer");
    chk_status_fixed: assert property (STATUS_BYTE[7:6] == 2'h2 && !STATUS_BYTE[5] &&
        !STATUS_BYTE[3])
        else $error("fixed status bits wrong");
    chk_lock_on_early_end: assert property (lock_set |=> ##1 LOCKED && STATUS_BYTE[2])
        else $error("lock not shown in status");

endmodule
`default_nettype wire

// ===== dv/bus_peer_model.sv
// Purpose: far-side unit model that puts fields on the decoder inputs
// Assumes: one field per send pulse, parity made here
// Notes:   a released field bus shows the inverted value, not the last one
`timescale 1ns/1ps
`default_nettype none
module bus_peer_model (
    input  wire logic        send,
    input  wire logic [2:0]  kind,
    input  wire logic [11:0] bits,
    input  wire logic        corrupt,
    output logic             field_valid,
    output logic [2:0]       field_kind,
    output logic [11:0]      field_bits,
    output logic             field_parity
);
    // ==================================================================
    // field drive
    assign field_valid  = send;
    assign field_kind   = kind;
    assign field_bits   = send ? bits : ~bits;
    // corrupt flips parity so that refusals can be provoked
    assign field_parity = (^bits) ^ corrupt;
endmodule
`default_nettype wire

// ===== dv/test_bus_unit_ack_and_control_decoder.sv
// Purpose: self-checking bench of the acknowledge and control decoder
// Assumes: unit address 123h, answers seen in the cycle after the take
// Notes:   control codes run from a table, faults and locking by hand
`timescale 1ns/1ps
`default_nettype none
module test_bus_unit_ack_and_control_decoder;
    localparam logic [11:0] UA = 12'h123;
    logic        clk, rst, send, bad, terr, bcast, fend, rdack, txe, rxe, rxf;
    logic        fv, fp, par_out, ack_valid, ack_bit, stop, dir, rx_push, tx_pop, locked;
    logic        txreq, rxen, txcfg;
    logic [2:0]  kind, fk;
    logic [3:0]  cmd;
    logic [11:0] bits, pin, owner, fb;
    logic [7:0]  reply, rx_data, status;
    int          n_mismatch, checks;
    // row: code, tx fifo empty, rx fifo empty, 0, refused
    logic [7:0]  rows [20] = '{8'h04, 8'h15, 8'h25, 8'h34, 8'h45, 8'h54, 8'h64, 8'h74,
        8'h85, 8'h95, 8'hA4, 8'hB4, 8'hC5, 8'hD5, 8'hE4, 8'hF4, 8'h7D, 8'h3D, 8'hF1, 8'hB1};

    bus_peer_model bus_peer_model_inst (.send(send), .kind(kind), .bits(bits),
        .corrupt(bad), .field_valid(fv), .field_kind(fk), .field_bits(fb), .field_parity(fp));
    bus_unit_ack_and_control_decoder bus_unit_ack_and_control_decoder_inst (
        .CLK(clk), .RST(rst), .FIELD_VALID(fv), .FIELD_KIND(fk), .FIELD_BITS(fb),
        .FIELD_PARITY(fp), .TIMING_ERR(terr), .BROADCAST(bcast), .FRAME_END(fend),
        .READ_BYTE_ACKED(rdack), .UNIT_ADDR(UA), .SLAVE_TX_REQUEST(txreq),
        .SLAVE_RX_ENABLE(rxen), .SLAVE_TX_ENABLE_CFG(txcfg), .TX_FIFO_EMPTY(txe),
        .TX_FIFO_DATA(8'h5A), .RX_FIFO_EMPTY(rxe), .RX_FIFO_FULL(rxf), .PAR_IN(pin),
        .PAR_OUT(par_out), .ACK_VALID(ack_valid), .ACK_BIT(ack_bit), .STOP(stop),
        .CMD_CODE(cmd), .DIR_TO_SLAVE(dir), .REPLY_BYTE(reply), .RX_DATA(rx_data),
        .RX_PUSH(rx_push), .TX_POP(tx_pop), .STATUS_BYTE(status), .LOCKED(locked),
        .LOCK_OWNER(owner));

    // ==================================================================
    // tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // timing error is raised the cycle before the field, as the bit layer would
    task automatic fld(input logic [2:0] k, input logic [11:0] b, input logic pb,
                       input logic te, input logic [1:0] exp);
        @(posedge clk);
        terr <= te;
        @(posedge clk);
        terr <= 1'b0;
        send <= 1'b1;
        kind <= k;
        bits <= b;
        bad  <= pb;
        @(posedge clk);
        send <= 1'b0;
        bad  <= 1'b0;
        #1;
        chk({14'h0000, ack_valid, ack_bit}, {14'h0000, exp});
    endtask
    task automatic hdr(input logic [11:0] m);
        fld(3'h0, m, 1'b0, 1'b0, 2'b01);
        fld(3'h1, UA, 1'b0, 1'b0, 2'b10);
    endtask
    task automatic fin();
        @(posedge clk);
        fend <= 1'b1;
        @(posedge clk);
        fend <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==================================================================
    // clock and stimulus
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst, send, bad, terr, bcast, fend, rdack, txe, rxe, rxf} = 10'b10_0000_0010;
        {kind, bits, pin, n_mismatch, checks} = '0;
        {txreq, rxen, txcfg} = 3'b111;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        pin <= 12'h007;
        #1;
        chk(status, 12'h080);
        @(posedge clk);
        pin <= 12'h003;
        #1;
        chk(par_out, 1'b1);
        @(posedge clk);
        #1;
        chk(par_out, 1'b0);
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            txe <= rows[i][3];
            rxe <= rows[i][2];
            hdr(12'h111);
            fld(3'h2, {8'h00, rows[i][7:4]}, 1'b0, 1'b0, {1'b1, rows[i][0]});
            if (!rows[i][0]) chk(dir, rows[i][7]);
            if (!rows[i][0]) chk(cmd, rows[i][7:4]);
            fin();
        end
        @(posedge clk);
        txe <= 1'b0;
        rxe <= 1'b1;
        fld(3'h0, 12'h111, 1'b1, 1'b0, 2'b01);
        fld(3'h1, UA, 1'b0, 1'b0, 2'b11);
        chk(stop, 1'b1);
        fin();
        fld(3'h0, 12'h111, 1'b0, 1'b0, 2'b01);
        fld(3'h1, UA, 1'b1, 1'b0, 2'b11);
        chk(stop, 1'b1);
        fin();
        fld(3'h0, 12'h111, 1'b0, 1'b0, 2'b01);
        fld(3'h1, 12'h124, 1'b0, 1'b1, 2'b11);
        fin();
        hdr(12'h111);
        fld(3'h2, 12'h00F, 1'b1, 1'b0, 2'b11);
        fin();
        hdr(12'h111);
        fld(3'h2, 12'h00F, 1'b0, 1'b1, 2'b11);
        fin();
        hdr(12'h111);
        fld(3'h2, 12'h00F, 1'b0, 1'b0, 2'b10);
        fld(3'h3, 12'h002, 1'b1, 1'b0, 2'b11);
        chk(stop, 1'b1);
        fin();
        hdr(12'h111);
        fld(3'h2, 12'h00F, 1'b0, 1'b0, 2'b10);
        fld(3'h3, 12'h002, 1'b0, 1'b0, 2'b10);
        rxf <= 1'b1;
        fld(3'h4, 12'h0A5, 1'b0, 1'b0, 2'b11);
        chk(stop, 1'b0);
        rxf <= 1'b0;
        fld(3'h4, 12'h0A5, 1'b0, 1'b0, 2'b10);
        chk({rx_push, rx_data}, 12'h1A5);
        fld(3'h4, 12'h03C, 1'b1, 1'b0, 2'b11);
        fin();
        hdr(12'h111);
        fld(3'h2, 12'h00B, 1'b0, 1'b0, 2'b10);
        fld(3'h3, 12'h002, 1'b0, 1'b0, 2'b10);
        fld(3'h4, 12'h001, 1'b0, 1'b0, 2'b10);
        fin();
        chk({locked, owner}, 13'h1111);
        chk(status, 12'h095);
        hdr(12'h222);
        fld(3'h2, 12'h00F, 1'b0, 1'b0, 2'b11);
        fin();
        for (int c = 4; c < 6; c++) begin
            hdr(12'h222);
            fld(3'h2, c[11:0], 1'b0, 1'b0, 2'b10);
            @(posedge clk);
            #1;
            chk(reply, (c == 4) ? 12'h011 : 12'h001);
            fin();
        end
        hdr(12'h111);
        fld(3'h2, 12'h007, 1'b0, 1'b0, 2'b10);
        fld(3'h3, 12'h001, 1'b0, 1'b0, 2'b01);
        chk(reply, 12'h05A);
        @(posedge clk);
        rdack <= 1'b1;
        @(posedge clk);
        rdack <= 1'b0;
        #1;
        chk(tx_pop, 1'b1);
        fin();
        hdr(12'h111);
        fld(3'h2, 12'h006, 1'b0, 1'b0, 2'b10);
        fld(3'h3, 12'h001, 1'b0, 1'b0, 2'b01);
        @(posedge clk);
        rdack <= 1'b1;
        @(posedge clk);
        rdack <= 1'b0;
        fin();
        chk({locked, status}, 9'h091);
        txreq <= 1'b0;
        rxen  <= 1'b0;
        txcfg <= 1'b0;
        hdr(12'h111);
        fld(3'h2, 12'h007, 1'b0, 1'b0, 2'b11);
        fin();
        hdr(12'h111);
        fld(3'h2, 12'h00F, 1'b0, 1'b0, 2'b11);
        fin();
        chk(status, 16'h0080);
        @(posedge clk);
        bcast <= 1'b1;
        fld(3'h0, 12'h111, 1'b0, 1'b0, 2'b01);
        fld(3'h1, 12'hFFF, 1'b0, 1'b0, 2'b01);
        fin();
        summarize();
    end
endmodule
`default_nettype wire
